// file: verilog/split_timer_pkg.sv
package split_timer_pkg;

  // Register offsets on the peripheral byte bus
  localparam logic [5:0] OFS_CTRL_E_CLR   = 6'h04;
  localparam logic [5:0] OFS_CTRL_E_SET   = 6'h05;
  localparam logic [5:0] OFS_INT_ENABLE   = 6'h0A;
  localparam logic [5:0] OFS_INT_FLAGS    = 6'h0B;
  localparam logic [5:0] OFS_DEBUG_CTRL   = 6'h0E;
  localparam logic [5:0] OFS_LOW_COUNT    = 6'h20;
  localparam logic [5:0] OFS_HIGH_COUNT   = 6'h21;
  localparam logic [5:0] OFS_LOW_PERIOD   = 6'h26;
  localparam logic [5:0] OFS_HIGH_PERIOD  = 6'h27;
  localparam logic [5:0] OFS_LOW_CMP_BASE = 6'h28;

  // Field positions
  localparam int CMD_LSB    = 2;
  localparam int TARGET_LSB = 0;
  localparam int FLAG_LOW_UNDERFLOW  = 0;
  localparam int FLAG_HIGH_UNDERFLOW  = 1;
  localparam int FLAG_CMP0  = 4;
  localparam int DBG_RUN    = 0;

  // Stored bit masks and reset values
  localparam logic [7:0] CTRL_E_STORE_MASK = 8'h03;
  localparam logic [7:0] INT_MASK          = 8'h73;
  localparam logic [7:0] COUNT_RESET       = 8'h00;
  localparam logic [7:0] PERIOD_RESET      = 8'hFF;
  localparam logic [7:0] CMP_RESET         = 8'h00;

  // Command codes and target selection
  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET   = 2'h3;
  localparam logic [1:0] TARGET_BOTH = 2'h3;

  // One register bus access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } bus_req_type;

endpackage : split_timer_pkg

// file: verilog/byte_down_counter.sv
`timescale 1ns/100ps
// One 8-bit down counter with write priority and reload from period
module byte_down_counter
  import split_timer_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic       tick_i,
  input  wire logic       restart_i,
  input  wire logic       write_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] period_i,
  output logic      [7:0] count_o,
  output logic            zero_o
);
  import split_timer_pkg::*;

  logic [7:0] next_count;

  // Host write first, then restart, then count or reload
  always_comb
  begin
    next_count = count_o;
    if (write_i)
      next_count = wdata_i;                            // [R15]
    else if (restart_i)
      next_count = COUNT_RESET;                        // [R23]
    else if (tick_i)
      next_count = (count_o == 8'h00) ? period_i      // [R21]
                                      : count_o - 8'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      count_o <= COUNT_RESET;                          // [R16]
    else
      count_o <= next_count;
  end

  // Count_zero reached: a tick that lands the count on zero
  assign zero_o = tick_i && !write_i && !restart_i
                  && (count_o == 8'h01);

endmodule : byte_down_counter

// file: verilog/tick_divider.sv
`timescale 1ns/100ps
// Prescaled tick: one pulse every DIV cycles while run_i is high
module tick_divider #(
  parameter int DIV = 1
) (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic run_i,
  output logic      tick_o
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  // Refuse a divider that could never produce a tick
  if (DIV < 1)
  begin : g_bad_div
    $error("tick_divider: DIV must be at least 1");
  end

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         wrap;

  assign wrap = (cnt == W'(DIV - 1));

  always_comb
  begin
    next_cnt = cnt;
    if (run_i)
      next_cnt = wrap ? '0 : cnt + W'(1);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign tick_o = run_i && wrap;

endmodule : tick_divider

// file: verilog/split_timer_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Command field always reads zero in set and clear views.
// [R2] Command 2 restarts, 3 hard-resets unless enabled, 0 and 1 do nothing.
// [R3] Command acts only when target select is 3 (both counters).
// [R4] Software pairs each command with target select both for hard reset.
// [R5] Set view write sets bits written one, others unchanged.
// [R6] Clear view write clears bits written one, others unchanged.
// [R7] Enables 6..4 gate compare flags 2..0 onto the interrupt request.
// [R8] Enable 1 gates high underflow, enable 0 low underflow.
// [R9] Compare flag sets whenever low count equals its compare value.
// [R10] Flags stay set until software writes one to clear.
// [R11] High underflow flag sets when high counter reaches zero.
// [R12] Low underflow flag sets when low counter reaches zero.
// [R13] Run-in-debug zero: halted processor stops counters and events.
// [R14] Run-in-debug one: counting continues while processor halted.
// [R15] Register write beats count, clear or reload in same cycle.
// [R16] Each counter is an 8-bit read-write register resetting to zero.
// [R17] Low period holds low top value, resets to 0xFF.
// [R18] High period holds high top value, resets to 0xFF.
// [R19] Split enable makes two independent 8-bit timers.
// [R20] Low compare values are compared continuously with low count.
// [R21] Counters count down per tick, reload period after zero.
// [R22] Both control E views read the same stored bits.
// [R23] Restart zeroes counters, keeps period and compare values.
module split_timer_regs
  import split_timer_pkg::*;
#(
  parameter int PRESCALE = 1,
  parameter int CHANNELS = 3
) (
  input  wire logic                    mclk_i,
  input  wire logic                    reset_n_i,
  input  wire split_timer_pkg::bus_req_type bus_i,
  input  wire logic                    enable_i,
  input  wire logic                    split_enable_i,
  input  wire logic                    cpu_halted_i,
  input  wire logic                    event_i,
  output logic      [7:0]              rdata_o,
  output logic                         irq_o,
  output logic      [CHANNELS-1:0]     cmp_match_o
);
  import split_timer_pkg::*;

  // Flag and enable bytes only have room for three compare channels
  if (CHANNELS < 1 || CHANNELS > 3)
  begin : g_bad_channels
    $error("split_timer_regs: CHANNELS must be 1 to 3");
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage

  logic [7:0] ctrl_e;
  logic [7:0] int_enable;
  logic [7:0] int_flags;
  logic [7:0] debug_ctrl;
  logic [7:0] low_period;
  logic [7:0] high_period;
  logic [7:0] low_cmp [CHANNELS];
  logic [7:0] next_ctrl_e;
  logic [7:0] next_int_enable;
  logic [7:0] next_int_flags;
  logic [7:0] next_debug_ctrl;
  logic [7:0] next_low_period;
  logic [7:0] next_high_period;
  logic [7:0] next_low_cmp [CHANNELS];
  logic [7:0] low_count;
  logic [7:0] high_count;
  logic       low_zero;
  logic       high_zero;
  logic       run;
  logic       tick;
  logic       ctrl_wr;
  logic [1:0] cmd;
  logic       cmd_both;
  logic       do_restart;
  logic       do_hard_reset;
  logic       wr_low_cnt;
  logic       wr_high_cnt;
  logic [7:0] hw_set;

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  assign ctrl_wr  = bus_i.wr && (bus_i.addr == OFS_CTRL_E_SET
                              || bus_i.addr == OFS_CTRL_E_CLR);
  assign cmd      = bus_i.wdata[CMD_LSB +: 2];
  // Target comes with the same write; reserved targets do nothing
  assign cmd_both = bus_i.wdata[TARGET_LSB +: 2] == TARGET_BOTH; // [R3]
  assign do_restart    = ctrl_wr && cmd_both
                         && (cmd == CMD_RESTART);              // [R2]
  // Hard reset refused while the timer is enabled
  assign do_hard_reset = ctrl_wr && cmd_both && !enable_i
                         && (cmd == CMD_RESET);                // [R2]

  // Debug halt freezes counting and drops events
  assign run = enable_i && split_enable_i                      // [R19]
               && (!cpu_halted_i || debug_ctrl[DBG_RUN]);      // [R13] [R14]

  assign wr_low_cnt  = bus_i.wr && bus_i.addr == OFS_LOW_COUNT;
  assign wr_high_cnt = bus_i.wr && bus_i.addr == OFS_HIGH_COUNT;

  ////////////////////////////////////////////////////////////////////////
  // Counters

  tick_divider #(
    .DIV (PRESCALE)
  ) u_div (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .run_i     (run),
    .tick_o    (tick)
  );

  byte_down_counter u_low (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .tick_i    (tick),
    .restart_i (do_restart || do_hard_reset),                  // [R23]
    .write_i   (wr_low_cnt),                                   // [R15]
    .wdata_i   (bus_i.wdata),
    .period_i  (low_period),
    .count_o   (low_count),
    .zero_o    (low_zero)
  );

  byte_down_counter u_high (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .tick_i    (tick),
    .restart_i (do_restart || do_hard_reset),                  // [R23]
    .write_i   (wr_high_cnt),                                  // [R15]
    .wdata_i   (bus_i.wdata),
    .period_i  (high_period),
    .count_o   (high_count),
    .zero_o    (high_zero)
  );

  ////////////////////////////////////////////////////////////////////////
  // Compare channels and hardware flag sources

  always_comb
  begin
    hw_set = 8'h00;
    hw_set[FLAG_LOW_UNDERFLOW] = low_zero;                              // [R12]
    hw_set[FLAG_HIGH_UNDERFLOW] = high_zero;                             // [R11]
    for (int i = 0; i < CHANNELS; i++)
      hw_set[FLAG_CMP0 + i] = cmp_match_o[i];  // [R9] Even when stopped
  end

  // Continuous compare against the low count
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_cmp
      assign cmp_match_o[g] = (low_count == low_cmp[g]);       // [R20]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  always_comb
  begin
    next_ctrl_e      = ctrl_e;
    next_int_enable  = int_enable;
    next_debug_ctrl  = debug_ctrl;
    next_low_period  = low_period;
    next_high_period = high_period;
    for (int i = 0; i < CHANNELS; i++)
      next_low_cmp[i] = low_cmp[i];
    // Hardware set wins over a same-cycle clear
    next_int_flags = int_flags;
    if (bus_i.wr && bus_i.addr == OFS_INT_FLAGS)
      next_int_flags = int_flags & ~bus_i.wdata;               // [R10]
    next_int_flags = (next_int_flags | hw_set) & INT_MASK;
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        OFS_CTRL_E_SET:
          next_ctrl_e = ctrl_e
                        | (bus_i.wdata & CTRL_E_STORE_MASK);   // [R5]
        OFS_CTRL_E_CLR:
          next_ctrl_e = ctrl_e
                        & ~(bus_i.wdata & CTRL_E_STORE_MASK);  // [R6]
        OFS_INT_ENABLE:  next_int_enable  = bus_i.wdata & INT_MASK;
        OFS_DEBUG_CTRL:  next_debug_ctrl  = bus_i.wdata & 8'h01;
        OFS_LOW_PERIOD:  next_low_period  = bus_i.wdata;       // [R17]
        OFS_HIGH_PERIOD: next_high_period = bus_i.wdata;       // [R18]
        default:
        begin
          for (int i = 0; i < CHANNELS; i++)
            if (bus_i.addr == OFS_LOW_CMP_BASE + 6'(2 * i))
              next_low_cmp[i] = bus_i.wdata;
        end
      endcase
    end
    // Hard reset returns all but control E and debug control to its reset state
    if (do_hard_reset)
    begin
      next_int_enable  = 8'h00;
      next_int_flags   = 8'h00;
      next_low_period  = PERIOD_RESET;
      next_high_period = PERIOD_RESET;
      for (int i = 0; i < CHANNELS; i++)
        next_low_cmp[i] = CMP_RESET;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_e      <= 8'h00;
      int_enable  <= 8'h00;
      int_flags   <= 8'h00;
      debug_ctrl  <= 8'h00;
      low_period  <= PERIOD_RESET;                             // [R17]
      high_period <= PERIOD_RESET;                             // [R18]
      for (int i = 0; i < CHANNELS; i++)
        low_cmp[i] <= CMP_RESET;
    end
    else
    begin
      ctrl_e      <= next_ctrl_e;
      int_enable  <= next_int_enable;
      int_flags   <= next_int_flags;
      debug_ctrl  <= next_debug_ctrl;
      low_period  <= next_low_period;
      high_period <= next_high_period;
      for (int i = 0; i < CHANNELS; i++)
        low_cmp[i] <= next_low_cmp[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path and interrupt

  always_comb
  begin
    rdata_o = 8'h00;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        OFS_CTRL_E_SET,
        OFS_CTRL_E_CLR:  rdata_o = ctrl_e & CTRL_E_STORE_MASK; // [R1] [R22]
        OFS_INT_ENABLE:  rdata_o = int_enable;
        OFS_INT_FLAGS:   rdata_o = int_flags;
        OFS_DEBUG_CTRL:  rdata_o = debug_ctrl;
        OFS_LOW_COUNT:   rdata_o = low_count;                  // [R16]
        OFS_HIGH_COUNT:  rdata_o = high_count;                 // [R16]
        OFS_LOW_PERIOD:  rdata_o = low_period;
        OFS_HIGH_PERIOD: rdata_o = high_period;
        default:
        begin
          for (int i = 0; i < CHANNELS; i++)
            if (bus_i.addr == OFS_LOW_CMP_BASE + 6'(2 * i))
              rdata_o = low_cmp[i];
        end
      endcase
    end
  end

  // Request only where flag and enable are both set
  assign irq_o = |(int_flags & int_enable);                    // [R7] [R8]

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  flag_sticky_a: assert property ( // [R10]
    int_flags[FLAG_LOW_UNDERFLOW] && !do_hard_reset
    && !(bus_i.wr && bus_i.addr == OFS_INT_FLAGS)
    |=> int_flags[FLAG_LOW_UNDERFLOW])
    else $error("low underflow flag dropped without clear");

  low_unf_set_a: assert property ( // [R12]
    low_zero && !do_hard_reset |=> int_flags[FLAG_LOW_UNDERFLOW])
    else $error("low underflow flag not set");

  high_unf_set_a: assert property ( // [R11]
    high_zero && !do_hard_reset |=> int_flags[FLAG_HIGH_UNDERFLOW])
    else $error("high underflow flag not set");

  irq_gate_a: assert property ( // [R7] [R8]
    irq_o |-> |(int_flags & int_enable & INT_MASK))
    else $error("interrupt without enabled flag");

  cnt_write_a: assert property ( // [R15]
    wr_low_cnt |=> low_count == $past(bus_i.wdata))
    else $error("low count write lost");

  halt_freeze_a: assert property ( // [R13]
    cpu_halted_i && !debug_ctrl[DBG_RUN] && !wr_low_cnt && !do_restart
    && !do_hard_reset |=> $stable(low_count))
    else $error("counter moved while halted");

  cmd_read_a: assert property ( // [R1]
    bus_i.rd |-> rdata_o[3:2] == 2'b00 ||
      !(bus_i.addr == OFS_CTRL_E_SET || bus_i.addr == OFS_CTRL_E_CLR))
    else $error("command field read nonzero");

  restart_a: assert property ( // [R23]
    do_restart && !wr_low_cnt |=> low_count == 8'h00
    && $stable(low_period))
    else $error("restart did not clear counter");

  cmp_flag_a: assert property ( // [R9]
    cmp_match_o[0] && !do_hard_reset |=> int_flags[FLAG_CMP0])
    else $error("compare flag not set");

endmodule : split_timer_regs

// file: tb/test_split_timer_regs.sv
`timescale 1ns/100ps
module test_split_timer_regs;
  import split_timer_pkg::*;

  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_type;

  logic                  mclk_i;
  logic                  reset_n_i;
  bus_req_type           bus;
  logic                  enable_i;
  logic                  split_enable_i;
  logic                  cpu_halted_i;
  logic                  event_i;
  logic      [7:0]       rdata_o;
  logic                  irq_o;
  logic      [2:0]       cmp_match_o;
  logic      [7:0]       rd_val;
  int                    error_cnt;
  int                    num_checks;

  // Reset reads, then writes that each leave a known readback
  localparam row_type ROWS [19] = '{
    '{1'b0, OFS_LOW_COUNT, 8'h00, 8'h00}, '{1'b0, OFS_HIGH_COUNT, 8'h00, 8'h00},
    '{1'b0, OFS_LOW_PERIOD, 8'h00, 8'hFF}, '{1'b0, OFS_HIGH_PERIOD, 8'h00, 8'hFF},
    '{1'b0, OFS_CTRL_E_CLR, 8'h00, 8'h00}, '{1'b0, OFS_CTRL_E_SET, 8'h00, 8'h00},
    '{1'b0, OFS_INT_ENABLE, 8'h00, 8'h00}, '{1'b0, OFS_DEBUG_CTRL, 8'h00, 8'h00},
    '{1'b0, OFS_LOW_CMP_BASE, 8'h00, 8'h00},
    '{1'b1, OFS_LOW_COUNT, 8'h5A, 8'h5A}, '{1'b1, OFS_HIGH_COUNT, 8'hA5, 8'hA5},
    '{1'b1, OFS_LOW_PERIOD, 8'hC3, 8'hC3}, '{1'b1, OFS_HIGH_PERIOD, 8'h3C, 8'h3C},
    '{1'b1, OFS_INT_ENABLE, 8'hFF, 8'h73}, '{1'b1, OFS_DEBUG_CTRL, 8'hFF, 8'h01},
    '{1'b1, 6'h3F, 8'hFF, 8'h00}, '{1'b1, OFS_CTRL_E_SET, 8'h01, 8'h01},
    '{1'b1, OFS_CTRL_E_SET, 8'h02, 8'h03}, '{1'b1, OFS_CTRL_E_CLR, 8'h01, 8'h02}
  };

  split_timer_regs #(
    .PRESCALE (1),
    .CHANNELS (3)
  ) DUT (
    .mclk_i         (mclk_i),
    .reset_n_i      (reset_n_i),
    .bus_i          (bus),
    .enable_i       (enable_i),
    .split_enable_i (split_enable_i),
    .cpu_halted_i   (cpu_halted_i),
    .event_i        (event_i),
    .rdata_o        (rdata_o),
    .irq_o          (irq_o),
    .cmp_match_o    (cmp_match_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task check8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check8

  // Reload timing is loose, so only the upper bound is exact
  task check_le(input string name, input logic [7:0] lim, input logic [7:0] seen);
    num_checks++;
    if ((seen <= lim) !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected %s: expected at most %h, seen %h", name, lim, seen);
    end
  endtask : check_le

  task wrap_up;
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks start and end on a rising edge, one assignment per edge,
  // so back-to-back accesses never drive the bus twice in a time step
  task wr(input logic [5:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
  endtask : wr

  task rchk(input string name, input logic [5:0] a, input logic [7:0] exp);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    // Read data is taken at the edge that accepts the read
    @(posedge mclk_i);
    rd_val = rdata_o;
    check8(name, exp, rd_val);
  endtask : rchk

  task idle(input int n);
    bus <= '0;
    repeat (n) @(posedge mclk_i);
  endtask : idle

  task chk_out(input logic exp_irq, input logic [2:0] exp_cmp);
    bus <= '0;
    @(negedge mclk_i);
    check8("irq_o", {7'h00, exp_irq}, {7'h00, irq_o});
    check8("cmp_match_o", {5'h00, exp_cmp}, {5'h00, cmp_match_o});
    @(posedge mclk_i);
  endtask : chk_out

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock and a watchdog against a hung sequence
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    error_cnt = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    bus = '0;
    enable_i = 1'b0;
    split_enable_i = 1'b0;
    cpu_halted_i = 1'b0;
    event_i = 1'b0;
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        wr(ROWS[i].addr, ROWS[i].data);
      rchk("row", ROWS[i].addr, ROWS[i].exp);
    end
    // Wrong target, then reserved command: counts must not move
    wr(OFS_CTRL_E_SET, 8'h09);
    rchk("low count", OFS_LOW_COUNT, 8'h5A);
    wr(OFS_CTRL_E_CLR, 8'h03);
    wr(OFS_CTRL_E_SET, 8'h07);
    rchk("low count", OFS_LOW_COUNT, 8'h5A);
    wr(OFS_CTRL_E_SET, 8'h0B);
    rchk("low count", OFS_LOW_COUNT, 8'h00);
    rchk("high count", OFS_HIGH_COUNT, 8'h00);
    rchk("low period", OFS_LOW_PERIOD, 8'hC3);
    rchk("high period", OFS_HIGH_PERIOD, 8'h3C);
    // Hard reset refused while enabled, honoured once disabled
    enable_i <= 1'b1;
    wr(OFS_LOW_COUNT, 8'h11);
    wr(OFS_CTRL_E_SET, 8'h0F);
    rchk("low count", OFS_LOW_COUNT, 8'h11);
    rchk("low period", OFS_LOW_PERIOD, 8'hC3);
    enable_i <= 1'b0;
    wr(OFS_CTRL_E_SET, 8'h0F);
    rchk("low period", OFS_LOW_PERIOD, 8'hFF);
    rchk("low count", OFS_LOW_COUNT, 8'h00);
    // Short periods so both counters wrap many times
    wr(OFS_LOW_PERIOD, 8'h03);
    wr(OFS_HIGH_PERIOD, 8'h05);
    wr(OFS_LOW_CMP_BASE, 8'hF0);
    wr(OFS_LOW_CMP_BASE + 6'h02, 8'hF1);
    wr(OFS_LOW_CMP_BASE + 6'h04, 8'hF2);
    wr(OFS_INT_FLAGS, 8'hFF);
    rchk("flags", OFS_INT_FLAGS, 8'h00);
    enable_i <= 1'b1;
    split_enable_i <= 1'b1;
    idle(40);
    enable_i <= 1'b0;
    rchk("flags", OFS_INT_FLAGS, 8'h03);
    // 40 ticks: period 3 wraps every 4 ticks, period 5 every 6
    rchk("low count", OFS_LOW_COUNT, 8'h00);
    check_le("low count", 8'h03, rd_val);
    rchk("high count", OFS_HIGH_COUNT, 8'h02);
    check_le("high count", 8'h05, rd_val);
    chk_out(1'b0, 3'h0);
    wr(OFS_INT_ENABLE, 8'h01);
    chk_out(1'b1, 3'h0);
    wr(OFS_INT_ENABLE, 8'h02);
    chk_out(1'b1, 3'h0);
    wr(OFS_INT_FLAGS, 8'h01);
    rchk("flags", OFS_INT_FLAGS, 8'h02);
    wr(OFS_INT_FLAGS, 8'h02);
    chk_out(1'b0, 3'h0);
    // Halted processor: frozen unless run-in-debug is set
    enable_i <= 1'b1;
    cpu_halted_i <= 1'b1;
    wr(OFS_DEBUG_CTRL, 8'h00);
    wr(OFS_LOW_COUNT, 8'h02);
    idle(20);
    rchk("low count", OFS_LOW_COUNT, 8'h02);
    wr(OFS_INT_FLAGS, 8'h73);
    wr(OFS_DEBUG_CTRL, 8'h01);
    idle(30);
    rchk("flags", OFS_INT_FLAGS, 8'h03);
    // Write while counting: written value must land untouched
    wr(OFS_LOW_COUNT, 8'h80);
    rchk("low count", OFS_LOW_COUNT, 8'h80);
    enable_i <= 1'b0;
    cpu_halted_i <= 1'b0;
    // Static match on channel 0 keeps its flag set
    wr(OFS_LOW_CMP_BASE, 8'h07);
    wr(OFS_LOW_COUNT, 8'h07);
    wr(OFS_INT_FLAGS, 8'hFF);
    rchk("flags", OFS_INT_FLAGS, 8'h10);
    wr(OFS_INT_ENABLE, 8'h10);
    chk_out(1'b1, 3'h1);
    wr(OFS_INT_ENABLE, 8'h20);
    chk_out(1'b0, 3'h1);
    idle(2);
    wrap_up();
  end

endmodule : test_split_timer_regs
